// ===== src/psb_ctrl.sv
// Sideband and management logic of a pluggable four-lane module.
// Assumes host pins are asynchronous to aclk; the serial clock is sampled.
`timescale 1ns/1ps
`include "psb_defs.svh"

module psb_ctrl #(
    parameter logic [15:0] RST_MIN_CYC = 16'(`PSB_RST_MIN_CYC)
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [4:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             irq,
    input  wire logic        module_select_n,
    input  wire logic        module_reset_n,
    input  wire logic        low_power_request,
    input  wire logic        scl,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    output logic             presence_n,
    output logic             attention_irq_n_o,
    output logic             attention_irq_oe_n,
    output logic [3:0]       chan_tx_disable,
    output logic             power_limit
);

    psb_pkg::psb_pins_s pin_w;
    psb_pkg::psb_pins_s s1_r;
    psb_pkg::psb_pins_s s2_r;
    psb_pkg::psb_pins_s s3_r;
    psb_pkg::psb_ser_e  st_r;
    logic [15:0]        rst_cnt_r;
    logic [7:0]         init_cnt_r;
    logic               dnr_r;
    logic [1:0]         flags_r;
    logic [3:0]         cnt_r;
    logic [7:0]         sh_r;
    logic               rw_r;
    logic               phase_r;
    logic               nack_r;
    logic [1:0]         ptr_r;
    logic [3:0]         chan_r;
    logic [7:0]         user_r;
    logic               sda_oe_n_r;
    logic               attn_oe_n_r;
    logic               pwr_limit_r;
    logic [4:0]         awaddr_r;
    logic               have_aw_r;
    logic [31:0]        wdata_r;
    logic [3:0]         wstrb_r;
    logic               have_w_r;
    logic               awready_r;
    logic               wready_r;
    logic               bvalid_r;
    logic [1:0]         bresp_r;
    logic               arready_r;
    logic               rvalid_r;
    logic [31:0]        rdata_r;
    logic [1:0]         rresp_r;
    logic [2:0]         irq_stat_r;
    logic [2:0]         irq_mask_r;
    logic               irq_r;

    assign pin_w = {module_select_n, module_reset_n, low_power_request, scl, sda_i};

    // Double sync; s3 only delays s2 for edge finding
    always_ff @(posedge aclk)
    begin
        s1_r <= pin_w;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    logic sel_w;
    logic scl_rise;
    logic scl_fall;
    logic start_w;
    logic stop_w;
    assign sel_w    = !s2_r.sel_n;
    assign scl_rise = s2_r.scl && !s3_r.scl;
    assign scl_fall = !s2_r.scl && s3_r.scl;
    assign start_w  = s2_r.scl && s3_r.scl && s3_r.sda && !s2_r.sda;
    assign stop_w   = s2_r.scl && s3_r.scl && !s3_r.sda && s2_r.sda;

    // Reset pin filter
    logic rst_low;
    logic rst_hit;
    logic mod_rst;
    assign rst_low = !s2_r.rst_n;
    assign rst_hit = rst_low && (rst_cnt_r == RST_MIN_CYC - 16'h0001);
    assign mod_rst = rst_hit || (rst_low && rst_cnt_r == RST_MIN_CYC);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !rst_low)
            rst_cnt_r <= 16'h0000;
        else if (rst_cnt_r != RST_MIN_CYC)
            rst_cnt_r <= rst_cnt_r + 16'h0001;
    end

    // Data-not-ready holds until the init delay after any reset
    logic init_done;
    assign init_done = dnr_r && !mod_rst && (init_cnt_r == 8'(`PSB_INIT_CYC - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn || mod_rst)
        begin
            dnr_r      <= 1'b1;
            init_cnt_r <= 8'h00;
        end
        else if (init_done)
            dnr_r <= 1'b0;
        else if (dnr_r)
            init_cnt_r <= init_cnt_r + 8'h01;
    end

    function automatic logic [7:0] map_rd(input logic [1:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `PSB_M_STAT:  v = {6'h00, s2_r.lp, dnr_r};
            `PSB_M_FLAGS: v = {6'h00, flags_r};
            `PSB_M_CHAN:  v = {4'h0, chan_r};
            `PSB_M_USER:  v = user_r;
        endcase
        return v;
    endfunction : map_rd

    logic load_w;
    logic flag_rd;
    logic ser_wr;
    logic fault_set;
    assign load_w  = scl_fall && sel_w && !start_w && !stop_w
                     && ((st_r == psb_pkg::PSB_ACK && rw_r)
                     || (st_r == psb_pkg::PSB_MACK && !nack_r));
    assign flag_rd = load_w && ptr_r == `PSB_M_FLAGS;
    assign ser_wr  = scl_fall && sel_w && !start_w && !stop_w
                     && st_r == psb_pkg::PSB_RX && cnt_r == 4'h8 && !phase_r;

    // Serial slave; first written byte sets the map pointer
    always_ff @(posedge aclk)
    begin
        if (!aresetn || mod_rst)
        begin
            st_r       <= psb_pkg::PSB_IDLE;
            cnt_r      <= 4'h0;
            sh_r       <= 8'h00;
            rw_r       <= 1'b0;
            phase_r    <= 1'b0;
            nack_r     <= 1'b0;
            ptr_r      <= 2'h0;
            chan_r     <= `PSB_CHAN_RST;
            user_r     <= `PSB_USER_RST;
            sda_oe_n_r <= 1'b1;
        end
        else if (!sel_w || stop_w)
        begin
            st_r       <= psb_pkg::PSB_IDLE;
            sda_oe_n_r <= 1'b1;
        end
        else if (start_w)
        begin
            st_r       <= psb_pkg::PSB_ADDR;
            cnt_r      <= 4'h0;
            sda_oe_n_r <= 1'b1;
        end
        else if (scl_rise)
        begin
            if (st_r == psb_pkg::PSB_ADDR || st_r == psb_pkg::PSB_RX)
            begin
                sh_r  <= {sh_r[6:0], s2_r.sda};
                cnt_r <= cnt_r + 4'h1;
            end
            else if (st_r == psb_pkg::PSB_MACK)
                nack_r <= s2_r.sda;
        end
        else if (load_w)
        begin
            sh_r       <= map_rd(ptr_r);
            sda_oe_n_r <= map_rd(ptr_r) >> 7 != 8'h00;
            ptr_r      <= ptr_r + 2'h1;
            cnt_r      <= 4'h1;
            st_r       <= psb_pkg::PSB_TX;
        end
        else if (scl_fall)
        begin
            unique case (st_r)
                psb_pkg::PSB_IDLE: st_r <= psb_pkg::PSB_IDLE;
                psb_pkg::PSB_ADDR:
                    if (cnt_r == 4'h8)
                    begin
                        if (sh_r[7:1] == `PSB_DEV_ADDR)
                        begin
                            rw_r       <= sh_r[0];
                            phase_r    <= !sh_r[0];
                            sda_oe_n_r <= 1'b0;
                            st_r       <= psb_pkg::PSB_ACK;
                        end
                        else
                            st_r <= psb_pkg::PSB_IDLE;
                    end
                psb_pkg::PSB_RX:
                    if (cnt_r == 4'h8)
                    begin
                        if (phase_r)
                            ptr_r <= sh_r[1:0];
                        else
                        begin
                            if (ptr_r == `PSB_M_CHAN)
                                chan_r <= sh_r[3:0];
                            else if (ptr_r == `PSB_M_USER)
                                user_r <= sh_r;
                            ptr_r <= ptr_r + 2'h1;
                        end
                        phase_r    <= 1'b0;
                        sda_oe_n_r <= 1'b0;
                        st_r       <= psb_pkg::PSB_ACK;
                    end
                psb_pkg::PSB_ACK:
                begin
                    sda_oe_n_r <= 1'b1;
                    cnt_r      <= 4'h0;
                    st_r       <= psb_pkg::PSB_RX;
                end
                psb_pkg::PSB_TX:
                    if (cnt_r == 4'h8)
                    begin
                        sda_oe_n_r <= 1'b1;
                        st_r       <= psb_pkg::PSB_MACK;
                    end
                    else
                    begin
                        sda_oe_n_r <= sh_r[6];
                        sh_r       <= {sh_r[6:0], 1'b0};
                        cnt_r      <= cnt_r + 4'h1;
                    end
                psb_pkg::PSB_MACK: st_r <= psb_pkg::PSB_IDLE;
                default:           st_r <= psb_pkg::PSB_IDLE;
            endcase
        end
    end

    // Sticky flags; a new event wins over the read that clears
    always_ff @(posedge aclk)
    begin
        if (!aresetn || mod_rst)
            flags_r <= 2'h0;
        else
            flags_r <= (flags_r & ~{2{flag_rd}}) | {fault_set, init_done};
    end

    // Pins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            attn_oe_n_r <= 1'b1;
            pwr_limit_r <= 1'b1;
        end
        else
        begin
            attn_oe_n_r <= !((|flags_r) && !dnr_r);
            pwr_limit_r <= s2_r.lp;
        end
    end

    // Register bus slave
    logic wr_do;
    assign wr_do = have_aw_r && have_w_r && !bvalid_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            have_aw_r <= 1'b0;
            have_w_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            awaddr_r  <= 5'h00;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_r)
            begin
                awaddr_r  <= s_axi_awaddr;
                have_aw_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r)
            begin
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
                have_w_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_do)
            begin
                have_aw_r <= 1'b0;
                have_w_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
                bvalid_r  <= 1'b1;
                bresp_r   <= (awaddr_r > `PSB_A_IRQ_MASK || awaddr_r[1:0] != 2'h0)
                             ? 2'h2 : 2'h0;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    assign fault_set = wr_do && awaddr_r == `PSB_A_CTRL && wstrb_r[0]
                       && wdata_r[`PSB_CTRL_FAULT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_mask_r <= `PSB_MASK_RST;
        else if (wr_do && awaddr_r == `PSB_A_IRQ_MASK && wstrb_r[0])
            irq_mask_r <= wdata_r[2:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= 2'h0;
        end
        else if (s_axi_arvalid && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= 2'h0;
            unique case (s_axi_araddr)
                `PSB_A_CTRL:     rdata_r <= 32'h00000000;
                `PSB_A_STATUS:   rdata_r <= {24'h000000, !attn_oe_n_r, chan_r,
                                             s2_r.lp, sel_w, dnr_r};
                `PSB_A_IRQ_STAT: rdata_r <= {29'h00000000, irq_stat_r};
                `PSB_A_IRQ_MASK: rdata_r <= {29'h00000000, irq_mask_r};
                default:
                begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= 2'h2;
                end
            endcase
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    logic stat_rd;
    assign stat_rd = s_axi_arvalid && arready_r && s_axi_araddr == `PSB_A_IRQ_STAT;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_r <= 3'h0;
            irq_r      <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~{3{stat_rd}}) | {ser_wr, rst_hit, init_done};
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign s_axi_awready      = awready_r;
    assign s_axi_wready       = wready_r;
    assign s_axi_bvalid       = bvalid_r;
    assign s_axi_bresp        = bresp_r;
    assign s_axi_arready      = arready_r;
    assign s_axi_rvalid       = rvalid_r;
    assign s_axi_rdata        = rdata_r;
    assign s_axi_rresp        = rresp_r;
    assign irq                = irq_r;
    assign sda_oe_n           = sda_oe_n_r;
    assign sda_o              = 1'b0; // Open drain: only the enable moves
    assign presence_n         = 1'b0;
    assign attention_irq_n_o  = 1'b0;
    assign attention_irq_oe_n = attn_oe_n_r;
    assign chan_tx_disable    = chan_r;
    assign power_limit        = pwr_limit_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sel_idle: assert property (!sel_w |=> st_r == psb_pkg::PSB_IDLE && sda_oe_n_r)
        else $error("serial logic active while deselected");
    a_map_ptr: assert property (load_w |=> ptr_r == $past(ptr_r) + 2'h1)
        else $error("read pointer did not advance");
    a_rst_full: assert property (rst_hit |=> dnr_r && chan_r == 4'h0 && flags_r == 2'h0)
        else $error("module reset incomplete");
    a_rst_short: assert property (!rst_low |=> rst_cnt_r == 16'h0000)
        else $error("reset filter kept count across a high");
    a_done_dnr: assert property (!attn_oe_n_r |-> !$past(dnr_r))
        else $error("interrupt posted while not ready");
    a_power_up: assert property ($fell(dnr_r) |-> flags_r[`PSB_FLG_RDONE] ##1 !attn_oe_n_r)
        else $error("no completion interrupt after init");
    a_lp_level: assert property (s2_r.lp |=> pwr_limit_r)
        else $error("power limit ignores low power input");
    a_pins_low: assert property (!presence_n && !attention_irq_n_o)
        else $error("presence or interrupt data not low");
    a_flag_clr: assert property (flag_rd && !fault_set && !init_done |=> flags_r == 2'h0)
        else $error("flags survived a read");
    a_chan_hold: assert property (!ser_wr && !mod_rst |=> $stable(chan_r))
        else $error("channel disables changed without a write");
    a_bresp_hold: assert property (bvalid_r && !s_axi_bready |=> bvalid_r)
        else $error("write response dropped");

    c_ser_write: cover property (ser_wr && ptr_r == `PSB_M_CHAN);
    c_flag_read: cover property (flag_rd ##[1:200] attn_oe_n_r);
    c_rst_pulse: cover property (rst_hit ##[1:100] init_done);

endmodule : psb_ctrl

// ===== src/psb_defs.svh
// Constants of the pluggable module sideband controller: offsets, fields,
// reset values and timing counts. Assumes a 20 MHz aclk.
`ifndef PSB_DEFS_SVH
`define PSB_DEFS_SVH

`define PSB_CLK_NS      50
`define PSB_RST_MIN_NS  10000
`define PSB_RST_MIN_CYC ((`PSB_RST_MIN_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS)
`define PSB_INIT_NS     2000
`define PSB_INIT_CYC    ((`PSB_INIT_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS)

// Arbitrary 7-bit serial device address
`define PSB_DEV_ADDR    7'h2A

// Register bus byte offsets
`define PSB_A_CTRL      5'h00
`define PSB_A_STATUS    5'h04
`define PSB_A_IRQ_STAT  5'h08
`define PSB_A_IRQ_MASK  5'h0C

// Serial memory map byte indices
`define PSB_M_STAT      2'h0
`define PSB_M_FLAGS     2'h1
`define PSB_M_CHAN      2'h2
`define PSB_M_USER      2'h3

// Field positions
`define PSB_CTRL_FAULT  0
`define PSB_FLG_RDONE   0
`define PSB_FLG_FAULT   1
`define PSB_IRQ_RDONE   0
`define PSB_IRQ_HRST    1
`define PSB_IRQ_WRITE   2

// Reset values
`define PSB_CHAN_RST    4'h0
`define PSB_USER_RST    8'h00
`define PSB_MASK_RST    3'h0

`endif

// ===== src/psb_pkg.sv
// Types of the pluggable module sideband controller.
// Constants live in psb_defs.svh.
package psb_pkg;

    typedef enum logic [2:0] {
        PSB_IDLE = 3'b000,
        PSB_ADDR = 3'b001,
        PSB_ACK  = 3'b010,
        PSB_RX   = 3'b011,
        PSB_TX   = 3'b100,
        PSB_MACK = 3'b101
    } psb_ser_e;

    typedef struct packed {
        logic sel_n;
        logic rst_n;
        logic lp;
        logic scl;
        logic sda;
    } psb_pins_s;

endpackage : psb_pkg

// ===== verif/psb_host_model.sv
// Host board model for one module: select, reset, low-power and a serial master.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`include "psb_defs.svh"

module psb_host_model (
    input  wire logic aclk,
    input  wire logic sda,
    output logic      sel_n,
    output logic      rst_n,
    output logic      lp,
    output logic      scl,
    output logic      sda_oe_n
);
    initial
    begin
        sel_n    = 1'h1;
        rst_n    = 1'h1;
        lp       = 1'h0;
        scl      = 1'h1;
        sda_oe_n = 1'h1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // Each module has its own select line; only this one is driven
    task automatic set_pins(input logic s, input logic l);
        sel_n <= s;
        lp    <= l;
    endtask : set_pins

    task automatic pulse_reset(input int n);
        rst_n <= 1'h0;
        tick(n);
        rst_n <= 1'h1;
    endtask : pulse_reset

    // Data moves a cycle after scl falls, so it never races the clock edge
    task automatic bit_io(input logic o, output logic i);
        tick(1);
        sda_oe_n <= o;
        tick(3);
        scl <= 1'h1;
        tick(4);
        i = sda;
        scl <= 1'h0;
    endtask : bit_io

    // Serves from idle and as a repeated start
    task automatic start;
        tick(1);
        sda_oe_n <= 1'h1;
        tick(3);
        scl <= 1'h1;
        tick(4);
        sda_oe_n <= 1'h0;
        tick(4);
        scl <= 1'h0;
    endtask : start

    task automatic stop;
        tick(1);
        sda_oe_n <= 1'h0;
        tick(3);
        scl <= 1'h1;
        tick(4);
        sda_oe_n <= 1'h1;
        tick(4);
    endtask : stop

    task automatic wr_byte(input logic [7:0] d, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'h1, s);
        a = !s;
    endtask : wr_byte

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, d[i]);
        bit_io(last, s);
    endtask : rd_byte

    task automatic map_wr(input logic [1:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        wr_byte({`PSB_DEV_ADDR, 1'h0}, a0);
        wr_byte({6'h00, p}, a1);
        wr_byte(d, a2);
        stop();
        ok = a0 && a1 && a2;
    endtask : map_wr

    task automatic map_rd(input logic [1:0] p, output logic [7:0] d);
        logic a0;
        start();
        wr_byte({`PSB_DEV_ADDR, 1'h0}, a0);
        wr_byte({6'h00, p}, a0);
        start();
        wr_byte({`PSB_DEV_ADDR, 1'h1}, a0);
        rd_byte(1'h1, d);
        stop();
    endtask : map_rd
endmodule : psb_host_model

// ===== verif/tb_pluggable_module_sideband_ctrl.sv
// Bench of the sideband controller: AXI4-Lite tasks plus the host board model.
// Assumes psb_host_model and the design sources are compiled alongside.
`timescale 1ns/1ps
`include "psb_defs.svh"

module tb_pluggable_module_sideband_ctrl;
    logic        aclk    = 1'h0;
    logic        aresetn = 1'h0;
    logic        awvalid = 1'h0;
    logic        wvalid  = 1'h0;
    logic        bready  = 1'h0;
    logic        arvalid = 1'h0;
    logic        rready  = 1'h0;
    logic [4:0]  awaddr  = 5'h00;
    logic [4:0]  araddr  = 5'h00;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, ack;
    logic        sel_n, rst_n, lp, scl, sda, sda_o, sda_oe_n, h_oe_n;
    logic        presence_n, att_o, att_oe_n, att_line, plim;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, rd;
    logic [3:0]  chan;
    logic [7:0]  b;
    int          num_errors = 0;
    int          num_checks = 0;

    always #25 aclk = ~aclk;
    assign sda = ((!sda_oe_n && !sda_o) || !h_oe_n) ? 1'h0 : 1'h1;
    assign att_line = (!att_oe_n && !att_o) ? 1'h0 : 1'h1;

    psb_ctrl #(.RST_MIN_CYC(16'h0008)) u_psb_ctrl (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq(irq),
        .module_select_n(sel_n), .module_reset_n(rst_n), .low_power_request(lp),
        .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .presence_n(presence_n), .attention_irq_n_o(att_o),
        .attention_irq_oe_n(att_oe_n), .chan_tx_disable(chan), .power_limit(plim));

    psb_host_model u_psb_host_model (
        .aclk(aclk), .sda(sda), .sel_n(sel_n), .rst_n(rst_n), .lp(lp),
        .scl(scl), .sda_oe_n(h_oe_n));

    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] e);
        awvalid <= 1'h1;
        awaddr  <= a;
        wvalid  <= 1'h1;
        wdata   <= d;
        wstrb   <= s;
        bready  <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        // Ready stays high so back-to-back calls never toggle it in one step
        e = bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] e);
        arvalid <= 1'h1;
        araddr  <= a;
        rready  <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        d = rdata;
        e = rresp;
    endtask : axi_rd

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (20000) @(posedge aclk);
        $display("watchdog expired");
        num_errors++;
        test_done();
    end

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        u_psb_host_model.tick(2);
        chk_bit("presence_n", 1'h0, presence_n);
        chk_bit("attention", 1'h1, att_line);
        chk_word("chan", 32'h0, 32'(chan));
        u_psb_host_model.set_pins(1'h1, 1'h1);
        u_psb_host_model.tick(6);
        chk_bit("power_limit", 1'h1, plim);
        u_psb_host_model.set_pins(1'h1, 1'h0);
        u_psb_host_model.tick(6);
        chk_bit("power_limit", 1'h0, plim);
        $display("test pins done");
        u_psb_host_model.tick(50);
        chk_bit("attention", 1'h0, att_line);
        axi_rd(`PSB_A_STATUS, rd, r);
        chk_bit("data_not_ready", 1'h0, rd[0]);
        axi_rd(`PSB_A_IRQ_STAT, rd, r);
        chk_word("irq_stat", 32'h1, rd);
        axi_rd(`PSB_A_IRQ_STAT, rd, r);
        chk_word("irq_stat", 32'h0, rd);
        axi_rd(5'h10, rd, r);
        chk_word("unmapped rresp", 32'h2, 32'(r));
        axi_wr(5'h14, 32'h1, 4'hF, r);
        chk_word("unmapped bresp", 32'h2, 32'(r));
        axi_wr(`PSB_A_IRQ_MASK, 32'h5, 4'hF, r);
        axi_rd(`PSB_A_IRQ_MASK, rd, r);
        chk_word("irq_mask", 32'h5, rd);
        axi_wr(`PSB_A_IRQ_MASK, 32'h7, 4'h0, r);
        axi_rd(`PSB_A_IRQ_MASK, rd, r);
        chk_word("irq_mask no strobe", 32'h5, rd);
        chk_bit("irq", 1'h0, irq);
        $display("test registers done");
        u_psb_host_model.map_wr(2'h2, 8'h0F, ack);
        chk_bit("ack", 1'h0, ack);
        chk_word("chan", 32'h0, 32'(chan));
        u_psb_host_model.set_pins(1'h0, 1'h0);
        u_psb_host_model.tick(4);
        for (int k = 0; k < 4; k++)
        begin
            u_psb_host_model.map_wr(2'h2, 8'h01 << k, ack);
            chk_bit("ack", 1'h1, ack);
            chk_word("chan", 32'h1 << k, 32'(chan));
        end
        chk_bit("irq", 1'h1, irq);
        axi_rd(`PSB_A_STATUS, rd, r);
        chk_word("status", 32'hC2, rd);
        axi_rd(`PSB_A_IRQ_STAT, rd, r);
        chk_word("irq_stat", 32'h4, rd);
        u_psb_host_model.tick(2);
        chk_bit("irq", 1'h0, irq);
        u_psb_host_model.map_rd(2'h2, b);
        chk_word("map chan", 32'h8, 32'(b));
        u_psb_host_model.map_rd(2'h1, b);
        chk_word("map flags", 32'h1, 32'(b));
        u_psb_host_model.tick(4);
        chk_bit("attention", 1'h1, att_line);
        axi_wr(`PSB_A_CTRL, 32'h1, 4'hF, r);
        u_psb_host_model.tick(6);
        chk_bit("attention", 1'h0, att_line);
        u_psb_host_model.map_rd(2'h1, b);
        chk_word("map flags", 32'h2, 32'(b));
        u_psb_host_model.tick(4);
        chk_bit("attention", 1'h1, att_line);
        $display("test serial done");
        axi_rd(`PSB_A_IRQ_STAT, rd, r);
        u_psb_host_model.pulse_reset(4);
        u_psb_host_model.tick(20);
        chk_word("chan", 32'h8, 32'(chan));
        u_psb_host_model.pulse_reset(20);
        u_psb_host_model.tick(5);
        chk_word("chan", 32'h0, 32'(chan));
        chk_bit("attention", 1'h1, att_line);
        axi_rd(`PSB_A_STATUS, rd, r);
        chk_bit("data_not_ready", 1'h1, rd[0]);
        u_psb_host_model.tick(60);
        chk_bit("attention", 1'h0, att_line);
        axi_rd(`PSB_A_IRQ_STAT, rd, r);
        chk_word("irq_stat", 32'h3, rd);
        $display("test module reset done");
        test_done();
    end
endmodule : tb_pluggable_module_sideband_ctrl
